/* verilog/vdsr_pkg.sv */
`default_nettype none
package vdsr_pkg;
  // Sub-addresses
  localparam logic [7:0] ADDR_REQUEST    = 8'h0A;
  localparam logic [7:0] ADDR_STATUS     = 8'h10;
  localparam logic [7:0] ADDR_COPY_PROT  = 8'h11;
  localparam logic [7:0] ADDR_CAPTION_LO = 8'h12;
  localparam logic [7:0] ADDR_CAPTION_HI = 8'h13;
  localparam logic [7:0] ADDR_AUX_LO     = 8'h14;
  localparam logic [7:0] ADDR_AUX_HI     = 8'h15;
  localparam logic [7:0] ADDR_CGEN_1     = 8'h16;
  localparam logic [7:0] ADDR_CGEN_2     = 8'h17;
  localparam logic [7:0] ADDR_ID         = 8'h18;

  // Decode-request bit positions
  localparam int REQ_CAPTION_BIT = 0;
  localparam int REQ_AUX_BIT     = 1;
  localparam int REQ_COPYGEN_BIT = 2;

  // Word widths and split points
  localparam int CAPTION_WIDTH = 16;
  localparam int COPYGEN_WIDTH = 14;
  localparam int CGEN_HI_WIDTH = 6;

  // Values after reset and for unmapped reads
  localparam logic [7:0]  RDATA_RESET   = 8'h00;
  localparam logic [7:0]  UNMAPPED_DATA = 8'h00;
  localparam logic [15:0] WORD_RESET    = 16'h0000;

  typedef enum logic [1:0] {
    SLOT_IDLE  = 2'b01,
    SLOT_ARMED = 2'b10
  } vdsr_slot_state_type;
endpackage
`default_nettype wire

/* verilog/vdsr_slot_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface vdsr_slot_if #(parameter int W = 16);
  logic         clear;
  logic         arm;
  logic         done;
  logic [W-1:0] word_in;
  logic [W-1:0] word;
  logic         ready;
  modport slot  (input clear, input arm, input done, input word_in, output word, output ready);
  modport owner (output clear, output arm, output done, output word_in, input word, input ready);
endinterface
`default_nettype wire

/* verilog/vdsr_vbi_slot.sv */
`timescale 1ns/1ps
`default_nettype none
module vdsr_vbi_slot #(
  parameter int W = 16
) (
  input  wire logic  clk,
  input  wire logic  rst,
  vdsr_slot_if.slot  s
);
  if (W < 1 || W > 16) begin : g_bad_width
    $error("vdsr_vbi_slot: W must be 1..16");
  end

  vdsr_pkg::vdsr_slot_state_type state_q;
  logic [W-1:0]                  word_q;
  logic                          ready_q;
  logic                          capture;

  // Only a decode that completes while armed is kept
  assign capture = (state_q == vdsr_pkg::SLOT_ARMED) && s.done;
  assign s.word  = word_q;
  assign s.ready = ready_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= vdsr_pkg::SLOT_IDLE;
    end else begin
      case (state_q)
        vdsr_pkg::SLOT_IDLE:  if (s.arm) state_q <= vdsr_pkg::SLOT_ARMED;
        vdsr_pkg::SLOT_ARMED: if (!s.arm && s.done) state_q <= vdsr_pkg::SLOT_IDLE;
        default:              state_q <= vdsr_pkg::SLOT_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      word_q <= W'(vdsr_pkg::WORD_RESET);
    end else if (capture) begin
      word_q <= s.word_in;
    end
  end

  // Set wins over a clear in the same cycle, so a finished decode is never lost
  always_ff @(posedge clk) begin
    if (rst) begin
      ready_q <= 1'b0;
    end else if (capture) begin
      ready_q <= 1'b1;
    end else if (s.clear) begin
      ready_q <= 1'b0;
    end
  end

  sequence s_armed_done;
    (state_q == vdsr_pkg::SLOT_ARMED) && s.done;
  endsequence

  a_capture_sets: assert property (@(posedge clk) disable iff (rst)
    s_armed_done |=> ready_q && (word_q == $past(s.word_in)))
    else $error("decoded word not captured with ready flag");

  a_clear_drops: assert property (@(posedge clk) disable iff (rst)
    s.clear && !capture |=> !ready_q ##1 (ready_q -> $past(capture)))
    else $error("ready flag survived a decode request");

  a_idle_holds: assert property (@(posedge clk) disable iff (rst)
    (state_q == vdsr_pkg::SLOT_IDLE) |=> $stable(word_q))
    else $error("word changed while no decode was requested");
endmodule // vdsr_vbi_slot
`default_nettype wire

/* verilog/vdsr_read_mux.sv */
`timescale 1ns/1ps
`default_nettype none
module vdsr_read_mux (
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  status_byte,
  input  wire logic [7:0]  copy_byte,
  input  wire logic [15:0] caption_word,
  input  wire logic [15:0] aux_word,
  input  wire logic [13:0] copygen_word,
  input  wire logic [7:0]  id_byte,
  output logic      [7:0]  data,
  output logic             hit
);
  always_comb begin
    hit  = 1'b1;
    data = vdsr_pkg::UNMAPPED_DATA;
    case (addr)
      vdsr_pkg::ADDR_STATUS:     data = status_byte;
      vdsr_pkg::ADDR_COPY_PROT:  data = copy_byte;
      vdsr_pkg::ADDR_CAPTION_LO: data = caption_word[7:0];
      vdsr_pkg::ADDR_CAPTION_HI: data = caption_word[15:8];
      vdsr_pkg::ADDR_AUX_LO:     data = aux_word[7:0];
      vdsr_pkg::ADDR_AUX_HI:     data = aux_word[15:8];
      // Top two bits of the first copy-generation byte are reserved zeros
      vdsr_pkg::ADDR_CGEN_1:     data = {2'h0, copygen_word[13:8]};
      vdsr_pkg::ADDR_CGEN_2:     data = copygen_word[7:0];
      vdsr_pkg::ADDR_ID:         data = id_byte;
      default:                   hit  = 1'b0;
    endcase
  end
endmodule // vdsr_read_mux
`default_nettype wire

/* verilog/video_decoder_status_readout.sv */
`timescale 1ns/1ps
`default_nettype none
module video_decoder_status_readout #(
  parameter logic [5:0] PART_CODE = 6'h2A, // Arbitrary value
  parameter logic [1:0] SILICON_STEP = 2'h2 // Arbitrary value
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata_q,
  output logic             reg_rd_valid_q,
  input  wire logic        input_absent_flag,
  input  wire logic        colour_suppress_active,
  input  wire logic        input_overflow_flag,
  input  wire logic        vertical_unlocked_flag,
  input  wire logic        gain_loop_kind,
  input  wire logic        gain_disturb_found,
  input  wire logic        colour_stripe_found,
  input  wire logic        colour_stripe_variant,
  input  wire logic        sync_shrink_found,
  input  wire logic        field_porch_pulse_found,
  input  wire logic        gain_pulse_found,
  input  wire logic        fake_sync_found,
  input  wire logic        caption_done,
  input  wire logic [15:0] caption_word_in,
  input  wire logic        caption_aux_done,
  input  wire logic [15:0] caption_aux_word_in,
  input  wire logic        copygen_done,
  input  wire logic [13:0] copygen_word_in,
  output logic             caption_decode_request_q,
  output logic             caption_aux_decode_request_q,
  output logic             copygen_decode_request_q,
  output logic             input_absent_pin_q
);
  vdsr_slot_if #(.W(vdsr_pkg::CAPTION_WIDTH)) cap_if ();
  vdsr_slot_if #(.W(vdsr_pkg::CAPTION_WIDTH)) aux_if ();
  vdsr_slot_if #(.W(vdsr_pkg::COPYGEN_WIDTH)) cgen_if ();

  logic       req_write;
  logic       any_request;
  logic [7:0] status_byte;
  logic [7:0] copy_byte;
  logic [7:0] id_byte;
  logic [7:0] mux_data;
  logic       mux_hit;

  // Only the request sub-address has a write effect; all others fall through
  assign req_write   = reg_wr_en && (reg_addr == vdsr_pkg::ADDR_REQUEST);
  assign any_request = req_write && (reg_wdata[vdsr_pkg::REQ_CAPTION_BIT]
                                   || reg_wdata[vdsr_pkg::REQ_AUX_BIT]
                                   || reg_wdata[vdsr_pkg::REQ_COPYGEN_BIT]);

  // One request bit clears every flag, but arms only its own decoder
  assign cap_if.clear  = any_request;
  assign aux_if.clear  = any_request;
  assign cgen_if.clear = any_request;
  assign cap_if.arm    = req_write && reg_wdata[vdsr_pkg::REQ_CAPTION_BIT];
  assign aux_if.arm    = req_write && reg_wdata[vdsr_pkg::REQ_AUX_BIT];
  assign cgen_if.arm   = req_write && reg_wdata[vdsr_pkg::REQ_COPYGEN_BIT];
  assign cap_if.done     = caption_done;
  assign cap_if.word_in  = caption_word_in;
  assign aux_if.done     = caption_aux_done;
  assign aux_if.word_in  = caption_aux_word_in;
  assign cgen_if.done    = copygen_done;
  assign cgen_if.word_in = copygen_word_in;

  vdsr_vbi_slot #(.W(vdsr_pkg::CAPTION_WIDTH)) u_caption_slot (
    .clk (ref_clk),
    .rst (rst),
    .s   (cap_if.slot)
  );

  vdsr_vbi_slot #(.W(vdsr_pkg::CAPTION_WIDTH)) u_aux_slot (
    .clk (ref_clk),
    .rst (rst),
    .s   (aux_if.slot)
  );

  vdsr_vbi_slot #(.W(vdsr_pkg::COPYGEN_WIDTH)) u_copygen_slot (
    .clk (ref_clk),
    .rst (rst),
    .s   (cgen_if.slot)
  );

  assign status_byte[0] = input_absent_flag;
  assign status_byte[1] = colour_suppress_active;
  assign status_byte[2] = input_overflow_flag;
  assign status_byte[3] = vertical_unlocked_flag;
  assign status_byte[4] = gain_loop_kind;
  assign status_byte[5] = cap_if.ready;
  assign status_byte[6] = aux_if.ready;
  assign status_byte[7] = cgen_if.ready;

  assign copy_byte[0] = gain_disturb_found;
  assign copy_byte[1] = colour_stripe_found;
  assign copy_byte[2] = colour_stripe_variant;
  assign copy_byte[3] = sync_shrink_found;
  assign copy_byte[4] = field_porch_pulse_found;
  assign copy_byte[5] = gain_pulse_found;
  assign copy_byte[6] = fake_sync_found;
  assign copy_byte[7] = 1'b0;

  // Fixed by parameters, so no write path can reach it
  assign id_byte = {SILICON_STEP, PART_CODE};

  vdsr_read_mux u_read_mux (
    .addr         (reg_addr),
    .status_byte  (status_byte),
    .copy_byte    (copy_byte),
    .caption_word (cap_if.word),
    .aux_word     (aux_if.word),
    .copygen_word (cgen_if.word),
    .id_byte      (id_byte),
    .data         (mux_data),
    .hit          (mux_hit)
  );

  // Read data is a snapshot taken at the read edge and held until the next read
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata_q <= vdsr_pkg::RDATA_RESET;
    end else if (reg_rd_en) begin
      reg_rdata_q <= mux_hit ? mux_data : vdsr_pkg::UNMAPPED_DATA;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rd_valid_q <= 1'b0;
    end else begin
      reg_rd_valid_q <= reg_rd_en;
    end
  end

  // One-cycle request pulses toward the vertical-blanking decoders
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      caption_decode_request_q     <= 1'b0;
      caption_aux_decode_request_q <= 1'b0;
      copygen_decode_request_q     <= 1'b0;
    end else begin
      caption_decode_request_q     <= cap_if.arm;
      caption_aux_decode_request_q <= aux_if.arm;
      copygen_decode_request_q     <= cgen_if.arm;
    end
  end

  // Pin is high with no signal or out of vertical lock
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      input_absent_pin_q <= 1'b1;
    end else begin
      input_absent_pin_q <= input_absent_flag || vertical_unlocked_flag;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_read_at(logic [7:0] a);
    reg_rd_en && (reg_addr == a);
  endsequence

  // A request with no decode finishing beside it, so the clear must win
  sequence s_quiet_request;
    any_request && !caption_done && !caption_aux_done && !copygen_done;
  endsequence

  a_status_read: assert property (s_read_at(vdsr_pkg::ADDR_STATUS)
    |=> reg_rd_valid_q && (reg_rdata_q == $past({cgen_if.ready, aux_if.ready, cap_if.ready,
        gain_loop_kind, vertical_unlocked_flag, input_overflow_flag,
        colour_suppress_active, input_absent_flag})))
    else $error("status read returned wrong value");

  a_killer_bit: assert property (s_read_at(vdsr_pkg::ADDR_STATUS)
    |=> reg_rdata_q[1] == $past(colour_suppress_active))
    else $error("colour suppression bit wrong");

  a_overflow_bit: assert property (s_read_at(vdsr_pkg::ADDR_STATUS)
    |=> reg_rdata_q[2] == $past(input_overflow_flag))
    else $error("input overflow bit wrong");

  a_unlock_bit: assert property (s_read_at(vdsr_pkg::ADDR_STATUS)
    |=> reg_rdata_q[3] == $past(vertical_unlocked_flag))
    else $error("vertical lock bit wrong");

  a_gain_kind: assert property (s_read_at(vdsr_pkg::ADDR_STATUS)
    |=> reg_rdata_q[4] == $past(gain_loop_kind))
    else $error("gain regime bit wrong");

  a_status_flags: assert property (s_read_at(vdsr_pkg::ADDR_STATUS)
    |=> reg_rdata_q[7:5] == $past({cgen_if.ready, aux_if.ready, cap_if.ready}))
    else $error("ready flags misplaced in status byte");

  a_aux_flag: assert property (s_read_at(vdsr_pkg::ADDR_STATUS)
    |=> reg_rdata_q[6] == $past(aux_if.ready))
    else $error("extended caption flag wrong");

  a_cgen_flag: assert property (s_read_at(vdsr_pkg::ADDR_STATUS)
    |=> reg_rdata_q[7] == $past(cgen_if.ready))
    else $error("copy-generation flag wrong");

  a_copy_read: assert property (s_read_at(vdsr_pkg::ADDR_COPY_PROT)
    |=> (reg_rdata_q[7] == 1'b0)
        && (reg_rdata_q[2:0] == $past({colour_stripe_variant, colour_stripe_found,
                                       gain_disturb_found})))
    else $error("copy-protection read wrong");

  a_shrink_bit: assert property (s_read_at(vdsr_pkg::ADDR_COPY_PROT)
    |=> reg_rdata_q[3] == $past(sync_shrink_found))
    else $error("sync reduction bit wrong");

  a_porch_bit: assert property (s_read_at(vdsr_pkg::ADDR_COPY_PROT)
    |=> reg_rdata_q[4] == $past(field_porch_pulse_found))
    else $error("back porch pulse bit wrong");

  a_pulse_bit: assert property (s_read_at(vdsr_pkg::ADDR_COPY_PROT)
    |=> reg_rdata_q[5] == $past(gain_pulse_found))
    else $error("gain pulse bit wrong");

  a_fake_sync: assert property (s_read_at(vdsr_pkg::ADDR_COPY_PROT)
    |=> reg_rdata_q[6] == $past(fake_sync_found))
    else $error("pseudo sync bit wrong");

  a_caption_low: assert property (s_read_at(vdsr_pkg::ADDR_CAPTION_LO)
    |=> reg_rdata_q == $past(cap_if.word[7:0]))
    else $error("caption low byte wrong");

  a_caption_pair: assert property (s_read_at(vdsr_pkg::ADDR_CAPTION_HI)
    |=> reg_rdata_q == $past(cap_if.word[15:8]))
    else $error("caption high byte wrong");

  a_aux_pair: assert property (s_read_at(vdsr_pkg::ADDR_AUX_LO)
    |=> reg_rdata_q == $past(aux_if.word[7:0]))
    else $error("extended caption low byte wrong");

  a_aux_high: assert property (s_read_at(vdsr_pkg::ADDR_AUX_HI)
    |=> reg_rdata_q == $past(aux_if.word[15:8]))
    else $error("extended caption high byte wrong");

  a_cgen_split: assert property (s_read_at(vdsr_pkg::ADDR_CGEN_1)
    |=> reg_rdata_q == {2'h0, $past(cgen_if.word[13:8])})
    else $error("copy-generation first byte wrong");

  a_cgen_low: assert property (s_read_at(vdsr_pkg::ADDR_CGEN_2)
    |=> reg_rdata_q == $past(cgen_if.word[7:0]))
    else $error("copy-generation second byte wrong");

  a_id_fixed: assert property (s_read_at(vdsr_pkg::ADDR_ID)
    |=> reg_rdata_q == {SILICON_STEP, PART_CODE})
    else $error("identification byte wrong");

  a_req_clears: assert property (s_quiet_request
    |=> !cap_if.ready && !aux_if.ready && !cgen_if.ready)
    else $error("decode request did not clear ready flags");

  a_cap_req_pulse: assert property (1'b1
    |=> caption_decode_request_q == $past(req_write && reg_wdata[vdsr_pkg::REQ_CAPTION_BIT]))
    else $error("caption decode request pulse wrong");

  a_aux_req_pulse: assert property (1'b1
    |=> caption_aux_decode_request_q == $past(req_write && reg_wdata[vdsr_pkg::REQ_AUX_BIT]))
    else $error("extended caption decode request pulse wrong");

  a_cgen_req_pulse: assert property (1'b1
    |=> copygen_decode_request_q == $past(req_write && reg_wdata[vdsr_pkg::REQ_COPYGEN_BIT]))
    else $error("copy-generation decode request pulse wrong");

  a_pin_follows: assert property (1'b1
    |=> input_absent_pin_q == $past(input_absent_flag || vertical_unlocked_flag))
    else $error("signal absent pin wrong");

  a_ro_write_ignored: assert property (reg_wr_en && !req_write && !caption_done
    && !caption_aux_done && !copygen_done
    |=> $stable({cap_if.ready, aux_if.ready, cgen_if.ready, cap_if.word, aux_if.word,
                 cgen_if.word}))
    else $error("write to read-only bank changed state");

  a_read_hold: assert property (!reg_rd_en |=> $stable(reg_rdata_q) && !reg_rd_valid_q)
    else $error("read data changed without a read");
endmodule // video_decoder_status_readout
`default_nettype wire

/* sim/vdsr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module vdsr_host_model (
  input  wire logic       ref_clk,
  output logic            reg_wr_en,
  output logic            reg_rd_en,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // One strobe cycle per access; released lines flip so stale values never look valid
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_wr_en = wr;
    reg_rd_en = ~wr;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
endmodule // vdsr_host_model
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb;
  localparam logic [5:0] PART = 6'h15; // Arbitrary value
  localparam logic [1:0] STEP = 2'h3;  // Arbitrary value
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        reg_wr_en;
  logic        reg_rd_en;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata_q;
  logic        reg_rd_valid_q;
  logic [4:0]  st_in;
  logic [6:0]  cp_in;
  logic [2:0]  done;
  logic [2:0]  req_q;
  logic [2:0]  rdy;
  logic        pin_q;
  logic [15:0] cw;
  logic [15:0] aw;
  logic [13:0] gw;
  logic [15:0] cw_e;
  logic [15:0] aw_e;
  logic [13:0] gw_e;
  logic [7:0]  e_v;
  logic [7:0]  exp_q[$];
  int          error_cnt = 0;
  int          n_compared = 0;

  always #12.5 ref_clk = ~ref_clk;

  vdsr_host_model host_u (.ref_clk(ref_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
                          .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  video_decoder_status_readout #(.PART_CODE(PART), .SILICON_STEP(STEP)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .reg_rd_valid_q(reg_rd_valid_q), .input_absent_flag(st_in[0]),
    .colour_suppress_active(st_in[1]), .input_overflow_flag(st_in[2]),
    .vertical_unlocked_flag(st_in[3]), .gain_loop_kind(st_in[4]),
    .gain_disturb_found(cp_in[0]), .colour_stripe_found(cp_in[1]),
    .colour_stripe_variant(cp_in[2]), .sync_shrink_found(cp_in[3]),
    .field_porch_pulse_found(cp_in[4]), .gain_pulse_found(cp_in[5]),
    .fake_sync_found(cp_in[6]), .caption_done(done[0]), .caption_word_in(cw),
    .caption_aux_done(done[1]), .caption_aux_word_in(aw), .copygen_done(done[2]),
    .copygen_word_in(gw), .caption_decode_request_q(req_q[0]),
    .caption_aux_decode_request_q(req_q[1]), .copygen_decode_request_q(req_q[2]),
    .input_absent_pin_q(pin_q));

  function automatic logic [7:0] exp_at(input logic [7:0] a);
    case (a)
      vdsr_pkg::ADDR_STATUS:     return {rdy, st_in};
      vdsr_pkg::ADDR_COPY_PROT:  return {1'b0, cp_in};
      vdsr_pkg::ADDR_CAPTION_LO: return cw_e[7:0];
      vdsr_pkg::ADDR_CAPTION_HI: return cw_e[15:8];
      vdsr_pkg::ADDR_AUX_LO:     return aw_e[7:0];
      vdsr_pkg::ADDR_AUX_HI:     return aw_e[15:8];
      vdsr_pkg::ADDR_CGEN_1:     return {2'b00, gw_e[13:8]};
      vdsr_pkg::ADDR_CGEN_2:     return gw_e[7:0];
      vdsr_pkg::ADDR_ID:         return {STEP, PART};
      default:                   return 8'h00;
    endcase
  endfunction

  task automatic rd_chk(input logic [7:0] a);
    exp_q.push_back(exp_at(a));
    host_u.access(1'b0, a, 8'h00);
  endtask

  task automatic sweep();
    for (int a = 32'h10; a <= 32'h18; a++) rd_chk(8'(a));
  endtask

  // Fresh words on every lane, so an unarmed or idle lane capturing anything shows up
  task automatic decode(input int k, input logic armed);
    @(negedge ref_clk);
    cw = 16'($urandom);
    aw = 16'($urandom);
    gw = 14'($urandom);
    done[k] = 1'b1;
    @(negedge ref_clk);
    done = 3'b000;
    if (armed) begin
      rdy[k] = 1'b1;
      case (k)
        0: cw_e = cw;
        1: aw_e = aw;
        default: gw_e = gw;
      endcase
    end
  endtask

  task automatic request(input logic [7:0] d);
    host_u.access(1'b1, vdsr_pkg::ADDR_REQUEST, d);
    rdy = 3'b000;
    `CHK("requests", d[2:0], req_q)
  endtask

  task automatic end_sim();
    if (exp_q.size() != 0) begin
      error_cnt++;
      $display("Error rdata_queue expected 0 seen %0d", exp_q.size());
    end
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(negedge ref_clk) begin
    if (reg_rd_valid_q === 1'b1) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("Error rdata expected none seen %h", reg_rdata_q);
      end else begin
        e_v = exp_q.pop_front();
        `CHK("rdata", e_v, reg_rdata_q)
      end
    end
  end

  initial begin
    #(25ns * 4000);
    error_cnt++;
    $display("Error watchdog expected finish seen hang");
    end_sim();
  end

  initial begin
    void'($urandom(32'h2E50AC2F));
    {st_in, cp_in, done, rdy} = '0;
    {cw, aw, gw, cw_e, aw_e, gw_e} = '0;
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK("absent_pin_reset", 1'b1, pin_q)
    `CHK("requests_reset", 3'b000, req_q)
    rst = 1'b0;
    sweep();
    rd_chk(8'h20);
    rd_chk(vdsr_pkg::ADDR_REQUEST);
    $display("test reset_and_id done");

    for (int i = 0; i < 10; i++) begin
      @(negedge ref_clk);
      st_in = (i == 8) ? 5'h1F : 5'($urandom);
      cp_in = (i == 8) ? 7'h7F : 7'($urandom);
      rd_chk(vdsr_pkg::ADDR_STATUS);
      rd_chk(vdsr_pkg::ADDR_COPY_PROT);
      `CHK("absent_pin", st_in[0] | st_in[3], pin_q)
    end
    $display("test live_status done");

    request(8'h07);
    for (int k = 0; k < 3; k++) decode(k, 1'b1);
    sweep();
    request(8'hF9);
    rd_chk(vdsr_pkg::ADDR_STATUS);
    decode(1, 1'b0);
    decode(2, 1'b0);
    decode(0, 1'b1);
    decode(0, 1'b0);
    sweep();
    $display("test decode_flow done");

    for (int a = 32'h10; a <= 32'h18; a++) host_u.access(1'b1, 8'(a), 8'($urandom));
    sweep();
    $display("test write_ignored done");
    repeat (3) @(negedge ref_clk);
    end_sim();
  end
endmodule // tb
`default_nettype wire
